//--- include/ssm_pkg.sv
// What this block does
// - modulate only when enable bit combination holds
// - modulator is instantiated on every instance but runs only on modulating instances
// - division factor is integer plus numerator over 18432
// - step fields used exactly as programmed
// - shape zero is upward spread from the numerator, bypass zero active
// - integer and fraction fields hold division factor
package ssm_pkg;
  localparam logic [11:0] ctrl_off     = 12'h000;
  localparam logic [11:0] div_off      = 12'h004;
  localparam logic [11:0] frac_off     = 12'h008;
  localparam logic [11:0] fm_off       = 12'h00c;
  localparam logic [11:0] status_off   = 12'h010;
  localparam logic [11:0] offset_off   = 12'h014;
  localparam int          frac_den     = 18432;
  localparam logic [31:0] ctrl_reset   = 32'h0000_0001;
  localparam logic [31:0] div_reset    = 32'h0000_0000;
  localparam logic [31:0] frac_reset   = 32'h0000_0000;
  localparam logic [31:0] fm_reset     = 32'h4000_0000;
  localparam int          pd_bit       = 0;
  localparam int          sdm_bit      = 30;
  localparam int          byp_bit      = 30;
  localparam int          shape_bit    = 29;
  localparam int          mfi_lsb      = 0;
  localparam int          mfi_w        = 8;
  localparam int          reference_predivider_lsb     = 12;
  localparam int          reference_predivider_w       = 3;
  localparam int          mfn_w        = 15;
  localparam int          modulation_step_count_lsb   = 16;
  localparam int          modulation_step_count_w     = 11;
  localparam int          stepsz_w     = 10;

  typedef struct packed {
    logic                power_down;
    logic                sd_enable;
    logic                bypass;
    logic                shape;
    logic [modulation_step_count_w-1:0] step_count;
    logic [stepsz_w-1:0] step_inc;
    logic [reference_predivider_w-1:0]   predivider;
  } mod_cfg_s;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_up   = 2'b01,
    st_down = 2'b10
  } ramp_e;
endpackage

//--- rtl/ssm_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module ssm_ramp (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // configuration
  input  wire ssm_pkg::mod_cfg_s cfg,
  input  wire logic              run,
  // result
  output logic signed [23:0]     frac_offset,
  output logic                   ramp_up
);
  ssm_pkg::ramp_e                    state_reg;
  ssm_pkg::ramp_e                    state_next;
  logic [ssm_pkg::reference_predivider_w-1:0]        pre_cnt_reg;
  logic [ssm_pkg::modulation_step_count_w-1:0]      step_cnt_reg;
  logic signed [23:0]                offs_reg;

  // one enable pulse per divided reference cycle
  wire tick      = run && (pre_cnt_reg + 3'd1 >= cfg.predivider);
  wire last_step = (step_cnt_reg + 11'd1 >= cfg.step_count);
  wire signed [23:0] inc = {14'h0000, cfg.step_inc};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssm_pkg::st_idle: if (run) state_next = ssm_pkg::st_up;
      ssm_pkg::st_up:   if (!run) state_next = ssm_pkg::st_idle;
                        else if (tick && last_step) state_next = ssm_pkg::st_down;
      ssm_pkg::st_down: if (!run) state_next = ssm_pkg::st_idle;
                        else if (tick && last_step) state_next = ssm_pkg::st_up;
      default:          state_next = ssm_pkg::st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ssm_pkg::st_idle;
      pre_cnt_reg  <= '0;
      step_cnt_reg <= '0;
      offs_reg     <= '0;
    end else if (!run) begin
      state_reg    <= ssm_pkg::st_idle;
      pre_cnt_reg  <= '0;
      step_cnt_reg <= '0;
      offs_reg     <= '0;
    end else begin
      state_reg   <= state_next;
      pre_cnt_reg <= tick ? '0 : pre_cnt_reg + 3'd1;
      if (tick && state_reg != ssm_pkg::st_idle) begin
        step_cnt_reg <= last_step ? '0 : step_cnt_reg + 11'd1;
        offs_reg <= (state_reg == ssm_pkg::st_up) ? offs_reg + inc : offs_reg - inc;
      end
    end
  end

  assign frac_offset = offs_reg;
  assign ramp_up     = (state_reg == ssm_pkg::st_up);
endmodule
`default_nettype wire

//--- rtl/ssm_top.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ssm_top #(
  parameter bit MOD_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pll core controls
  output logic             pll_power_down,
  output logic             fm_active,
  output logic [7:0]       integer_multiplier,
  output logic [14:0]      fractional_numerator,
  output logic [2:0]       reference_predivider,
  output logic [23:0]      effective_numerator
);
  // register file
  logic [31:0]        pll_control_register;
  logic [31:0]        divider_register;
  logic [31:0]        fractional_divider_register;
  logic [31:0]        frequency_modulation_register;
  // bus answer, all from flops
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  // modulation state
  logic               fm_reg;
  logic [23:0]        eff_reg;
  logic signed [23:0] offs;
  ssm_pkg::mod_cfg_s  cfg;

  // byte lanes of a write folded into the stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0]  s
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // full 12-bit compare, so aliases of a word are refused
  function automatic logic at(
    input logic [11:0] a,
    input logic [11:0] off
  );
    return a == off;
  endfunction

  // bus phases
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  // writes land at the edge that completes the access
  wire wr       = access && pwrite && pready_reg;
  wire rd_setup = setup && !pwrite;

  // address decode
  wire hit_ctrl = at(paddr, ssm_pkg::ctrl_off);
  wire hit_div  = at(paddr, ssm_pkg::div_off);
  wire hit_frac = at(paddr, ssm_pkg::frac_off);
  wire hit_fm   = MOD_PRESENT && at(paddr, ssm_pkg::fm_off);
  wire hit_stat = at(paddr, ssm_pkg::status_off);
  wire hit_offs = MOD_PRESENT && at(paddr, ssm_pkg::offset_off);
  wire mapped   = hit_ctrl | hit_div | hit_frac | hit_fm | hit_stat | hit_offs;

  // per-register write enables
  wire wr_ctrl  = wr && hit_ctrl;
  wire wr_div   = wr && hit_div;
  wire wr_frac  = wr && hit_frac;
  wire wr_fm    = wr && hit_fm;

  // configuration fields
  assign cfg.power_down = pll_control_register[ssm_pkg::pd_bit];
  assign cfg.sd_enable  = fractional_divider_register[ssm_pkg::sdm_bit];
  assign cfg.bypass     = frequency_modulation_register[ssm_pkg::byp_bit];
  assign cfg.shape      = frequency_modulation_register[ssm_pkg::shape_bit];
  assign cfg.step_count = frequency_modulation_register[ssm_pkg::modulation_step_count_lsb +: ssm_pkg::modulation_step_count_w];
  assign cfg.step_inc   = frequency_modulation_register[ssm_pkg::stepsz_w-1:0];
  assign cfg.predivider = divider_register[ssm_pkg::reference_predivider_lsb +: ssm_pkg::reference_predivider_w];

  wire fm_next = MOD_PRESENT && !cfg.power_down && cfg.sd_enable && !cfg.bypass && !cfg.shape;

  wire [23:0] num_base = {9'h000, fractional_divider_register[ssm_pkg::mfn_w-1:0]};
  wire [23:0] eff_next = fm_reg ? num_base + offs : num_base;

  // read selection, sampled in the setup cycle
  wire [31:0] rd_mux =
    hit_ctrl ? pll_control_register :
    hit_div  ? divider_register :
    hit_frac ? fractional_divider_register :
    hit_fm   ? frequency_modulation_register :
    hit_stat ? {31'h0000_0000, fm_reg} :
    hit_offs ? {8'h00, offs} : 32'h0000_0000;

  // ramp direction is not needed outside
  ssm_ramp u_ramp (
    .pclk        (pclk),
    .presetn     (presetn),
    .cfg         (cfg),
    .run         (fm_reg),
    .frac_offset (offs),
    .ramp_up     ()
  );

  // control word, powered down out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_control_register <= ssm_pkg::ctrl_reset;
    end else if (wr_ctrl) begin
      pll_control_register <= merge(pll_control_register, pwdata, pstrb);
    end
  end

  // integer multiplier and predivider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_register <= ssm_pkg::div_reset;
    end else if (wr_div) begin
      divider_register <= merge(divider_register, pwdata, pstrb);
    end
  end

  // numerator and sigma delta enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fractional_divider_register <= ssm_pkg::frac_reset;
    end else if (wr_frac) begin
      fractional_divider_register <= merge(fractional_divider_register, pwdata, pstrb);
    end
  end

  // modulation word, bypassed out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frequency_modulation_register <= ssm_pkg::fm_reset;
    end else if (wr_fm) begin
      frequency_modulation_register <= merge(frequency_modulation_register, pwdata, pstrb);
    end
  end

  // ready raised in the one access cycle: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
    end
  end

  // status read right after the enabling write still shows the old mode;
  // one idle cycle between them is enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= rd_setup ? rd_mux : '0;
    end
  end

  // error decided in setup, shown during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup && !mapped;
    end
  end

  // mode flag, one cycle behind the configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_reg <= 1'b0;
    end else begin
      fm_reg <= fm_next;
    end
  end

  // offset added only while fm_reg is set, so the plain numerator passes outside modulation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_reg <= '0;
    end else begin
      eff_reg <= eff_next;
    end
  end

  // outputs straight from flops
  assign pready               = pready_reg;
  assign prdata               = prdata_reg;
  assign pslverr              = pslverr_reg;
  assign pll_power_down       = pll_control_register[ssm_pkg::pd_bit];
  assign fm_active            = fm_reg;
  assign integer_multiplier   = divider_register[ssm_pkg::mfi_lsb +: ssm_pkg::mfi_w];
  assign fractional_numerator = fractional_divider_register[ssm_pkg::mfn_w-1:0];
  assign reference_predivider = cfg.predivider;
  assign effective_numerator  = eff_reg;
endmodule
`default_nettype wire

//--- verification/ssm_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module ssm_top_chk #(
  parameter bit MOD_PRESENT = 1'b1
) (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core controls
  input wire logic        pll_power_down,
  input wire logic        fm_active,
  input wire logic [7:0]  integer_multiplier,
  input wire logic [14:0] fractional_numerator,
  input wire logic [2:0]  reference_predivider,
  input wire logic [23:0] effective_numerator
);
  wire logic acc = psel && penable;
  wire logic wr  = acc && pwrite && pstrb == 4'hf;
  // fm and offset words vanish on a non-modulating instance
  wire logic hit = paddr[1:0] == 2'h0 && paddr <= 12'h014
                   && (MOD_PRESENT || (paddr != 12'h00c && paddr != 12'h014));
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_idle2; !fm_active ##1 !fm_active; endsequence
  property p_ready; acc |-> pready; endproperty
  property p_err; acc |-> pslverr == !hit; endproperty
  property p_zero; acc && !pwrite && !hit |-> prdata == 32'h0000_0000; endproperty
  property p_ctrl; wr && paddr == 12'h000 |=> pll_power_down == $past(pwdata[0]); endproperty
  property p_div; wr && paddr == 12'h004 |=> integer_multiplier == $past(pwdata[7:0])
    && reference_predivider == $past(pwdata[14:12]); endproperty
  property p_frac; wr && paddr == 12'h008 |=> fractional_numerator == $past(pwdata[14:0]);
  endproperty
  property p_pd; pll_power_down |=> !fm_active; endproperty
  // read data is captured in setup, so it shows the mode of the cycle before
  property p_stat; acc && !pwrite && paddr == 12'h010 |-> prdata[0] == $past(fm_active);
  endproperty
  property p_idle; s_idle2 |-> effective_numerator == {9'h000, $past(fractional_numerator)};
  endproperty
  property p_none; 1'b1 |-> MOD_PRESENT || !fm_active; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  a_err: assert property (p_err) else $error("error flag wrong");
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  a_ctrl: assert property (p_ctrl) else $error("power down not stored");
  a_div: assert property (p_div) else $error("divider fields wrong");
  a_frac: assert property (p_frac) else $error("numerator wrong");
  a_pd: assert property (p_pd) else $error("modulating while down");
  a_stat: assert property (p_stat) else $error("status mismatch");
  a_idle: assert property (p_idle) else $error("offset while idle");
  a_none: assert property (p_none) else $error("modulation on plain pll");
endmodule
bind ssm_top ssm_top_chk #(.MOD_PRESENT(MOD_PRESENT)) u_ssm_top_chk (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .pstrb                (pstrb),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .pll_power_down       (pll_power_down),
  .fm_active            (fm_active),
  .integer_multiplier   (integer_multiplier),
  .fractional_numerator (fractional_numerator),
  .reference_predivider (reference_predivider),
  .effective_numerator  (effective_numerator)
);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, pll_power_down, fm_active;
  logic [7:0]  integer_multiplier;
  logic [14:0] fractional_numerator;
  logic [2:0]  reference_predivider;
  logic [23:0] effective_numerator;
  int          err_count = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  ssm_top u_ssm_top (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .pll_power_down       (pll_power_down),
    .fm_active            (fm_active),
    .integer_multiplier   (integer_multiplier),
    .fractional_numerator (fractional_numerator),
    .reference_predivider (reference_predivider),
    .effective_numerator  (effective_numerator)
  );
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t exp %h got %h", $time, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until ready is seen at a rising edge; the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(e, rd);
  endtask
  task t_reset;
    rdc(12'h000, 32'h0000_0001);
    rdc(12'h00c, 32'h4000_0000);
    rdc(12'h008, 32'h0000_0000);
  endtask
  task t_enable;
    apb(1'b1, 12'h004, 32'h0000_1031);
    apb(1'b1, 12'h008, 32'h0000_2d00);
    // 44 by 313 at 64 kHz, 1.5 percent depth
    apb(1'b1, 12'h00c, 32'h0139_002c);
    apb(1'b1, 12'h000, 32'h0000_0000);
    rdc(12'h010, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h4000_2d00);
    rdc(12'h010, 32'h0000_0001);
    chk(32'h0031_2d00, {8'h00, integer_multiplier, 1'b0, fractional_numerator});
    chk(32'h0000_0001, {29'h0, reference_predivider});
  endtask
  task t_modes;
    logic [11:0] ba[4] = '{12'h000, 12'h008, 12'h00c, 12'h00c};
    logic [31:0] bd[4] = '{32'h0000_0001, 32'h0000_2d00, 32'h4139_002c, 32'h2139_002c};
    logic [31:0] gd[4] = '{32'h0000_0000, 32'h4000_2d00, 32'h0139_002c, 32'h0139_002c};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ba[i], bd[i]);
      rdc(12'h010, 32'h0000_0000);
      apb(1'b1, ba[i], gd[i]);
      rdc(12'h010, 32'h0000_0001);
    end
  endtask
  task t_triangle;
    int dif, pk;
    pk = 0;
    // one step a cycle at predivider 1, so a full period fits in 700
    repeat (700) begin
      @(negedge pclk);
      dif = int'($signed(effective_numerator)) - 11520;
      if (dif < 0) dif = -dif;
      if (dif > pk) pk = dif;
    end
    chk(32'd13772, pk);
  endtask
  task t_unmapped;
    apb(1'b1, 12'h018, 32'h0000_1234);
    chk(32'h0000_0001, {31'h0, er});
    rdc(12'h018, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0, er});
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_enable();
    t_modes();
    t_triangle();
    t_unmapped();
    conclude();
  end
endmodule
`default_nettype wire
